// file: core/pwp_pkg.sv
package pwp_pkg;

  // Protection codes recognised by the rights decode
  localparam logic [15:0] PWP_CODE_BASIC_ONLY = 16'h0000;
  localparam logic [15:0] PWP_CODE_TO_EXT     = 16'h000b;
  localparam logic [15:0] PWP_CODE_TO_IO      = 16'h000c;
  localparam logic [15:0] PWP_CODE_ALL        = 16'h000d;
  localparam logic [15:0] PWP_CODE_LOCK_BASIC = 16'h100b;
  localparam logic [15:0] PWP_CODE_LOCK_ALL   = 16'h100d;
  localparam logic [15:0] PWP_CODE_RESET      = PWP_CODE_ALL;

  // Group numbers, one mask bit per group
  localparam int          PWP_NUM_GROUPS  = 5;
  localparam logic [2:0]  PWP_GRP_BASIC   = 3'h0;
  localparam logic [2:0]  PWP_GRP_GAIN    = 3'h1;
  localparam logic [2:0]  PWP_GRP_EXT     = 3'h2;
  localparam logic [2:0]  PWP_GRP_IO      = 3'h3;
  localparam logic [2:0]  PWP_GRP_SPECIAL = 3'h4;

  // Access masks, bit n set grants group n
  localparam logic [4:0]  PWP_MASK_NONE   = 5'h00;
  localparam logic [4:0]  PWP_MASK_BASIC  = 5'h01;
  localparam logic [4:0]  PWP_MASK_TO_EXT = 5'h07;
  localparam logic [4:0]  PWP_MASK_TO_IO  = 5'h0f;
  localparam logic [4:0]  PWP_MASK_ALL    = 5'h1f;

  typedef enum logic {PWP_ST_LOAD, PWP_ST_RUN} pwp_state_t;

endpackage : pwp_pkg

// file: core/pwp_rights_if.sv
interface pwp_rights_if;
  logic [15:0] code;
  logic [4:0]  rd_mask;
  logic [4:0]  wr_mask;
  logic        code_valid;

  modport dec (input code, output rd_mask, output wr_mask, output code_valid);
  modport usr (output code, input rd_mask, input wr_mask, input code_valid);
endinterface : pwp_rights_if

// file: core/pwp_rights_decode.sv
module pwp_rights_decode
  import pwp_pkg::*;
(
  pwp_rights_if.dec rights
);

  // Code to read mask, write mask, known flag
  function automatic logic [10:0] pwp_decode(input logic [15:0] code);
    logic [10:0] r;
    r = {PWP_MASK_BASIC, PWP_MASK_NONE, 1'b0};
    if (code == PWP_CODE_BASIC_ONLY) begin
      r = {PWP_MASK_BASIC, PWP_MASK_BASIC, 1'b1};
    end else if (code == PWP_CODE_TO_EXT) begin
      r = {PWP_MASK_TO_EXT, PWP_MASK_TO_EXT, 1'b1};
    end else if (code == PWP_CODE_TO_IO) begin
      r = {PWP_MASK_TO_IO, PWP_MASK_TO_IO, 1'b1};
    end else if (code == PWP_CODE_ALL) begin
      r = {PWP_MASK_ALL, PWP_MASK_ALL, 1'b1};
    end else if (code == PWP_CODE_LOCK_BASIC) begin
      r = {PWP_MASK_BASIC, PWP_MASK_NONE, 1'b1};
    end else if (code == PWP_CODE_LOCK_ALL) begin
      r = {PWP_MASK_ALL, PWP_MASK_NONE, 1'b1};
    end
    return r;
  endfunction

  // Rights table lookup
  // code to masks
  assign {rights.rd_mask, rights.wr_mask, rights.code_valid} = pwp_decode(rights.code);

endmodule : pwp_rights_decode

// file: core/pwp_access_guard.sv
// Behaviour
// - A newly written protection code is only applied at the next power-on or controller reset.
// - Code 000dh, the factory value, allows reading and writing of all five groups.
// - Code 0000h allows reading and writing of the basic group only.
// - Code 000bh opens basic, gain/filter and extension groups, 000ch adds I/O, special stays closed.
// - Codes 100bh and 100dh allow writes only to the lock setting, reads basic only or all groups.
// - Every parameter belongs to exactly one of five groups; other group numbers are refused.
module pwp_access_guard
  import pwp_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ctrl_reset_in,
  input  wire logic [15:0] nv_code_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [2:0]  req_group_in,
  input  wire logic        req_lock_in,
  input  wire logic [15:0] req_wdata_in,
  output logic             ack_out,
  output logic             grant_out,
  output logic             deny_out,
  output logic [15:0]      active_code_out,
  output logic [15:0]      pending_code_out,
  output logic             code_valid_out
);

  pwp_state_t  state_q;
  logic [15:0] active_q;
  logic [15:0] pending_q;
  logic [2:0]  creset_sync_q;
  logic        apply_pulse;
  logic        ack_q;
  logic        grant_q;
  logic        deny_q;
  logic        grp_ok;
  logic        lock_target;
  logic        rd_ok;
  logic        wr_ok;
  logic        allow;
  logic        lock_wr;

  pwp_rights_if rights ();

  pwp_rights_decode u_decode (
    .rights (rights.dec)
  );

  assign rights.code = active_q;

  // Controller reset pin synchroniser and edge
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      creset_sync_q <= 3'h0;
    end else begin
      creset_sync_q <= {creset_sync_q[1:0], ctrl_reset_in};
    end
  end

  assign apply_pulse = creset_sync_q[1] & ~creset_sync_q[2] & (state_q == PWP_ST_RUN);

  // Startup sequencer, loads stored code once
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= PWP_ST_LOAD;
    end else begin
      case (state_q)
        PWP_ST_LOAD: state_q <= PWP_ST_RUN;
        PWP_ST_RUN:  state_q <= PWP_ST_RUN;
        default:     state_q <= PWP_ST_LOAD;
      endcase
    end
  end

  // Permission check
  // group number range
  assign grp_ok      = req_group_in < 3'(PWP_NUM_GROUPS);
  assign lock_target = req_lock_in && (req_group_in == PWP_GRP_BASIC);
  assign rd_ok       = grp_ok && rights.rd_mask[req_group_in];
  assign wr_ok       = grp_ok && (rights.wr_mask[req_group_in] || lock_target);
  assign allow       = (state_q == PWP_ST_RUN) && (req_write_in ? wr_ok : rd_ok);
  assign lock_wr     = req_valid_in && req_write_in && lock_target && allow;

  // Active code, changes only on power-on load or controller reset
  // deferred code apply
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_q <= PWP_CODE_RESET;
    end else if (state_q == PWP_ST_LOAD) begin
      active_q <= nv_code_in;
    end else if (apply_pulse) begin
      active_q <= pending_q;
    end
  end

  // Pending code, written through the lock setting
  // write held pending
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pending_q <= PWP_CODE_RESET;
    end else if (state_q == PWP_ST_LOAD) begin
      pending_q <= nv_code_in;
    end else if (lock_wr) begin
      pending_q <= req_wdata_in;
    end
  end

  // Answer one cycle after each request
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q   <= 1'b0;
      grant_q <= 1'b0;
      deny_q  <= 1'b0;
    end else begin
      ack_q   <= req_valid_in;
      grant_q <= req_valid_in && allow;
      deny_q  <= req_valid_in && !allow;
    end
  end

  assign ack_out          = ack_q;
  assign grant_out        = grant_q;
  assign deny_out         = deny_q;
  assign active_code_out  = active_q;
  assign pending_code_out = pending_q;
  assign code_valid_out   = rights.code_valid;

  // Checks on the access rules
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  logic req_run;
  assign req_run = req_valid_in && (state_q == PWP_ST_RUN);

  AST_CODE_HELD: assert property (
    (state_q == PWP_ST_RUN) && !apply_pulse |=> $stable(active_code_out))
    else $error("active code changed without controller reset");

  AST_LOCK_PENDING: assert property (
    req_run && req_write_in && lock_target && !apply_pulse
    |=> grant_out && pending_code_out == $past(req_wdata_in) && $stable(active_code_out))
    else $error("lock write not held pending");

  AST_APPLY: assert property (
    apply_pulse |=> active_code_out == $past(pending_code_out))
    else $error("pending code not applied on controller reset");

  AST_FULL_ACCESS: assert property (
    req_run && active_code_out == PWP_CODE_ALL && grp_ok |=> ack_out && grant_out && !deny_out)
    else $error("factory code refused an access");

  AST_BASIC_ONLY: assert property (
    req_run && active_code_out == PWP_CODE_BASIC_ONLY && req_group_in != PWP_GRP_BASIC |=> deny_out)
    else $error("code 0000h allowed a non-basic group");

  AST_SPECIAL_CLOSED: assert property (
    req_run && (active_code_out == PWP_CODE_TO_EXT || active_code_out == PWP_CODE_TO_IO)
    && req_group_in == PWP_GRP_SPECIAL |=> deny_out)
    else $error("special group open under 000bh or 000ch");

  AST_IO_OPEN: assert property (
    req_run && active_code_out == PWP_CODE_TO_IO && req_group_in == PWP_GRP_IO |=> grant_out)
    else $error("I/O group closed under 000ch");

  AST_LOCK_ONLY: assert property (
    req_run && req_write_in && !lock_target
    && (active_code_out == PWP_CODE_LOCK_BASIC || active_code_out == PWP_CODE_LOCK_ALL) |=> deny_out)
    else $error("write allowed under lock-only code");

  AST_LOCK_READ_ALL: assert property (
    req_run && !req_write_in && grp_ok && active_code_out == PWP_CODE_LOCK_ALL |=> grant_out)
    else $error("read refused under 100dh");

  AST_GROUP_RANGE: assert property (
    req_valid_in && !grp_ok |=> deny_out && !grant_out)
    else $error("unmapped group number accepted");

  AST_UNKNOWN_CODE: assert property (
    req_run && req_write_in && !lock_target && !code_valid_out |=> deny_out)
    else $error("write allowed under unknown code");

  AST_LOAD_CODE: assert property (
    state_q == PWP_ST_LOAD |=> active_code_out == $past(nv_code_in) && pending_code_out == $past(nv_code_in))
    else $error("stored code not loaded after power-on");

  AST_LOAD_DENY: assert property (
    req_valid_in && state_q == PWP_ST_LOAD |=> deny_out && !grant_out)
    else $error("request granted in the load cycle");

  AST_PENDING_HELD: assert property (
    (state_q == PWP_ST_RUN) && !lock_wr |=> $stable(pending_code_out))
    else $error("pending code changed without a lock write");

  AST_ANSWER: assert property (
    req_valid_in |=> ack_out && (grant_out != deny_out))
    else $error("request not answered by exactly one verdict");

  AST_QUIET: assert property (
    !req_valid_in |=> !ack_out && !grant_out && !deny_out)
    else $error("answer without a request");

  AST_TO_EXT_RIGHTS: assert property (
    req_run && active_code_out == PWP_CODE_TO_EXT && grp_ok |=> grant_out == ($past(req_group_in) <= PWP_GRP_EXT))
    else $error("wrong verdict under 000bh");

  AST_LOCK_ALWAYS: assert property (
    req_run && req_write_in && lock_target |=> grant_out && !deny_out)
    else $error("lock setting write refused");

  AST_LOCK_BASIC_READ: assert property (
    req_run && !req_write_in && grp_ok && active_code_out == PWP_CODE_LOCK_BASIC
    |=> grant_out == ($past(req_group_in) == PWP_GRP_BASIC))
    else $error("wrong read verdict under 100bh");

  AST_UNKNOWN_READ: assert property (
    req_run && !req_write_in && grp_ok && !code_valid_out |=> grant_out == ($past(req_group_in) == PWP_GRP_BASIC))
    else $error("wrong read verdict under unknown code");

  COV_LOCK_THEN_APPLY: cover property (lock_wr ##[1:20] apply_pulse);
  COV_LOAD_REQ: cover property (req_valid_in && state_q == PWP_ST_LOAD);
  COV_UNKNOWN_ACTIVE: cover property (req_run && !code_valid_out);
  COV_DENY: cover property (req_run ##1 deny_out);
  COV_LOCK_ALL_READ: cover property (req_run && active_code_out == PWP_CODE_LOCK_ALL && !req_write_in);

endmodule : pwp_access_guard

// file: sim/pwp_ctrl_model.sv
module pwp_ctrl_model (
  input  wire logic        sys_clk_in,
  input  wire logic        ack_in,
  input  wire logic        grant_in,
  input  wire logic        deny_in,
  output logic             req_valid_out,
  output logic             req_write_out,
  output logic [2:0]       req_group_out,
  output logic             req_lock_out,
  output logic [15:0]      req_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_group_out = 3'h0;
    req_lock_out  = 1'b0;
    req_wdata_out = 16'h0000;
  end
  // One request, answer taken just after the edge at which it is seen, one cycle after it is driven
  task automatic access(input logic w, input logic [2:0] g, input logic lk, input logic [15:0] d,
                        output logic [2:0] rsp);
    @(posedge sys_clk_in);
    req_valid_out <= 1'b1;
    req_write_out <= w;
    req_group_out <= g;
    req_lock_out  <= lk;
    req_wdata_out <= d;
    @(posedge sys_clk_in);
    req_valid_out <= 1'b0;
    req_wdata_out <= ~d; // Released data stops showing old value
    #1;
    rsp = {ack_in, grant_in, deny_in};
  endtask
endmodule // pwp_ctrl_model

// file: sim/test_parameter_write_protect.sv
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module test_parameter_write_protect
  import pwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, ctrl_rst, valid, wr, lock, ack, grant, deny, cvalid;
  logic [2:0]  grp;
  logic [15:0] nv, wdata, active, pending;
  int          errors, cmp_count;
  logic [15:0] codes [7] = '{16'h0000, 16'h000b, 16'h000c, 16'h000d, 16'h100b, 16'h100d, 16'h1234};
  logic [4:0]  rd [7] = '{5'h01, 5'h07, 5'h0f, 5'h1f, 5'h01, 5'h1f, 5'h01};
  logic [4:0]  wm [7] = '{5'h01, 5'h07, 5'h0f, 5'h1f, 5'h00, 5'h00, 5'h00};

  pwp_access_guard i_pwp_access_guard (.sys_clk_in(clk), .rst_in(rst), .ctrl_reset_in(ctrl_rst),
    .nv_code_in(nv), .req_valid_in(valid), .req_write_in(wr), .req_group_in(grp), .req_lock_in(lock),
    .req_wdata_in(wdata), .ack_out(ack), .grant_out(grant), .deny_out(deny), .active_code_out(active),
    .pending_code_out(pending), .code_valid_out(cvalid));
  pwp_ctrl_model i_pwp_ctrl_model (.sys_clk_in(clk), .ack_in(ack), .grant_in(grant), .deny_in(deny),
    .req_valid_out(valid), .req_write_out(wr), .req_group_out(grp), .req_lock_out(lock),
    .req_wdata_out(wdata));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Power cycle, request in the load cycle is refused
  task automatic power_up(input logic [15:0] c);
    logic [2:0] rsp;
    rst <= 1'b1;
    nv  <= c;
    repeat (3) @(posedge clk);
    `CHK(active, 16'h000d)
    `CHK(cvalid, 1'b1)
    fork
      i_pwp_ctrl_model.access(1'b0, 3'h0, 1'b0, 16'h0000, rsp);
      begin @(posedge clk); rst <= 1'b0; end
    join
    `CHK(rsp, 3'b101)
    `CHK(active, c)
    `CHK(pending, c)
  endtask

  // Lock write, then controller reset applies it
  task automatic apply_code(input logic [15:0] c);
    logic [2:0]  rsp;
    logic [15:0] old;
    old = active;
    i_pwp_ctrl_model.access(1'b1, 3'h0, 1'b1, c, rsp);
    `CHK(rsp, 3'b110)
    `CHK(pending, c)
    `CHK(active, old)
    @(posedge clk);
    ctrl_rst <= 1'b1;
    for (int n = 0; n < 10 && active !== c; n++) begin
      @(posedge clk);
      #1;
    end
    if (active !== c) begin
      errors++;
      tally_and_finish();
    end
    @(posedge clk);
    ctrl_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Read and write every group number under the active code
  task automatic check_rights(input logic [4:0] rm, input logic [4:0] wmask);
    logic [2:0] rsp;
    logic       ok;
    for (int g = 0; g < 8; g++) begin
      for (int w = 0; w < 2; w++) begin
        ok = (g < 5) ? (w ? wmask[g] : rm[g]) : 1'b0;
        i_pwp_ctrl_model.access(w[0], g[2:0], 1'b0, 16'h5a5a, rsp);
        `CHK(rsp, {1'b1, ok, !ok})
      end
    end
  endtask

  // Main sequence
  initial begin
    rst      = 1'b1;
    ctrl_rst = 1'b0;
    nv       = 16'h000d;
    errors   = 0;
    cmp_count = 0;
    power_up(16'h000d);
    check_rights(5'h1f, 5'h1f);
    for (int i = 0; i < 7; i++) begin
      apply_code(codes[i]);
      `CHK(cvalid, (i < 6))
      check_rights(rd[i], wm[i]);
      `CHK(pending, codes[i])
    end
    @(posedge clk);
    power_up(16'h100b);
    check_rights(5'h01, 5'h00);
    tally_and_finish();
  end
endmodule // test_parameter_write_protect
